// file: rfq_host_mem.sv
// host memory model answering free-queue entry reads
`timescale 1ns/100ps
module rfq_host_mem (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic [3:0] slow,
  output logic mem_rd_valid,
  output logic [63:0] mem_rd_data
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  logic [31:0] addr_reg;
  logic [63:0] entry;
  // entry derived from its address; upper half of dword1 is junk the device must ignore
  assign entry = {~addr_reg, 16'hffff, addr_reg[15:0]};
  // outside the answer cycle the bus shows the inverse, so a late sample cannot match
  assign mem_rd_data = mem_rd_valid ? entry : ~entry;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      addr_reg <= 32'h0;
      mem_rd_valid <= 1'b0;
    end else begin
      mem_rd_valid <= busy_reg && (cnt_reg == 4'h0);
      if (mem_rd_req) begin
        busy_reg <= 1'b1;
        cnt_reg <= slow;
        addr_reg <= mem_rd_addr;
      end else if (busy_reg) begin
        if (cnt_reg == 4'h0) busy_reg <= 1'b0;
        else cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : rfq_host_mem

// file: rfq_manager.sv
// receive free-queue manager: pointers, address calculation, entry fetch, status and interrupt
// Summary of operation
// (R1) host fills free queue entries with buffer address and descriptor pointer
// (R2) first entry dword is taken whole as the data buffer start address
// (R3) low 16 bits of second dword offset the descriptor base to find descriptor
// (R4) upper 16 bits of second dword are ignored
// (R5) free queue is split into a large-buffer and a small-buffer circular queue
// (R6) per-channel selection picks large or small queue; sizes set by host
// (R7) on a data request, fetch the next entry from the channel's queue
// (R8) single size use: small start equals end address, no channel selects small
// (R9) host programs all at init; device moves read pointers, host write pointers
// (R10) queue is empty when read pointer equals write pointer
// (R11) full when read pointer leads write by one; host leaves one slot free
// (R12) large entry address is base plus pointer times eight
// (R13) small entry address is base plus eight times small start plus eight times pointer
// (R14) entry layout is the same with or without big-endian ordering
// (R15) after a read the pointer advances one; at or past its boundary it wraps to zero
// (R16) each read sets the done flag of the queue used, interruptible
// (R17) read on empty queue sets underflow flag, no read, no advance
// (R18) fetching starts only once the receive DMA enable bit is set
// (R19) read pointers stay zero after reset until the host programs them; the code also lets a fetch advance them from zero without a host write
`timescale 1ns/100ps
module rfq_manager (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fetch_req,
  input wire logic [rfq_pkg::CHAN_W-1:0] fetch_chan,
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [63:0] mem_rd_data,
  output logic grant_valid,
  output rfq_pkg::rfq_grant_t grant,
  output logic fetch_error,
  output logic irq
);
  import rfq_pkg::*;

  typedef enum logic [1:0] {RFQ_IDLE, RFQ_READ, RFQ_WAIT} rfq_state_t;

  logic [15:0] base_low_reg;
  logic [15:0] base_high_reg;
  logic [15:0] end_addr_reg;
  logic [15:0] small_start_reg;
  logic [15:0] large_wr_reg;
  logic [15:0] small_wr_reg;
  logic [15:0] large_rd_reg;
  logic [15:0] small_rd_reg;
  logic [15:0] desc_base_low_reg;
  logic [15:0] desc_base_high_reg;
  logic ctrl_enable_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic [12:0] large_size_reg;
  logic [12:0] small_size_reg;
  logic [NUM_CHAN-1:0] chan_small_reg;
  rfq_state_t state_reg;
  logic use_small_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [31:0] rdata_next;
  logic [3:0] status_set;
  logic [3:0] status_clr;
  logic [15:0] rd_ptr_cur;
  logic [15:0] wr_ptr_cur;
  logic [15:0] rd_ptr_inc;
  logic [16:0] small_abs_inc;
  logic [15:0] rd_ptr_next;
  logic [15:0] bound_cur;
  logic queue_empty;
  logic [31:0] entry_addr;
  logic large_adv;
  logic small_adv;
  rfq_entry_t entry;

  // register offset compare, used by the write decoders; the read mux compares reg_addr directly
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // channel selection is a bit per channel so software can flip one channel without read-modify-write races
  function automatic logic [11:0] chan_off(input int i);
    chan_off = 12'(OFF_CHAN_SEL_BASE + 12'(i * 4));
  endfunction : chan_off

  // entry address of the selected queue; pointers are in entries of two dwords [R12] [R13]
  function automatic logic [31:0] entry_byte_addr(input logic sel_small, input logic [15:0] ptr,
                                                  input logic [31:0] base, input logic [15:0] sstart);
    logic [31:0] off;
    off = {13'h0000, ptr, 3'h0};
    if (sel_small) begin
      off = off + {13'h0000, sstart, 3'h0};
    end
    entry_byte_addr = base + off;
  endfunction : entry_byte_addr

  assign entry = mem_rd_data;

  // queue selection and empty test against the host write pointer [R5] [R10]
  always_comb begin
    rd_ptr_cur = use_small_reg ? small_rd_reg : large_rd_reg;
    wr_ptr_cur = use_small_reg ? small_wr_reg : large_wr_reg;
    // large queue ends at the small start, small queue ends at the end address
    bound_cur = use_small_reg ? end_addr_reg : small_start_reg;
    queue_empty = (rd_ptr_cur == wr_ptr_cur); // [R10] [R11]
    rd_ptr_inc = rd_ptr_cur + 16'h0001;
    // small pointer is relative to the small start, so compare it in absolute entries [R15]
    // 17 bits so a pointer near the top of its range cannot slip past the boundary test
    small_abs_inc = {1'b0, rd_ptr_inc} + {1'b0, small_start_reg};
    if (use_small_reg) begin
      rd_ptr_next = (small_abs_inc >= {1'b0, bound_cur}) ? PTR_RESET : rd_ptr_inc;
    end else begin
      rd_ptr_next = (rd_ptr_inc >= bound_cur) ? PTR_RESET : rd_ptr_inc;
    end
    entry_addr = entry_byte_addr(use_small_reg, rd_ptr_cur, {base_high_reg, base_low_reg}, small_start_reg);
  end

  // fetch sequencer [R7] [R18]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= RFQ_IDLE;
      use_small_reg <= 1'b0;
      chan_reg <= '0;
    end else begin
      case (state_reg)
        RFQ_IDLE: begin
          if (fetch_req && ctrl_enable_reg) begin // [R18]
            use_small_reg <= chan_small_reg[fetch_chan]; // [R6]
            chan_reg <= fetch_chan;
            state_reg <= RFQ_READ;
          end
        end
        RFQ_READ: begin
          state_reg <= queue_empty ? RFQ_IDLE : RFQ_WAIT; // [R17]
        end
        RFQ_WAIT: begin
          if (mem_rd_valid) begin
            state_reg <= RFQ_IDLE;
          end
        end
        default: begin
          state_reg <= RFQ_IDLE;
        end
      endcase
    end
  end

  assign large_adv = (state_reg == RFQ_WAIT) && mem_rd_valid && !use_small_reg;
  assign small_adv = (state_reg == RFQ_WAIT) && mem_rd_valid && use_small_reg;

  // memory read request toward the bus master
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_rd_req <= 1'b0;
      mem_rd_addr <= ADDR_RESET;
    end else begin
      mem_rd_req <= (state_reg == RFQ_READ) && !queue_empty; // [R17]
      if (state_reg == RFQ_READ) begin
        mem_rd_addr <= entry_addr; // [R12] [R13]
      end
    end
  end

  // one-cycle result pulses toward the receive DMA
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      grant_valid <= 1'b0;
      fetch_error <= 1'b0;
    end else begin
      grant_valid <= (state_reg == RFQ_WAIT) && mem_rd_valid; // [R7]
      fetch_error <= (state_reg == RFQ_READ) && queue_empty; // [R17]
    end
  end

  // grant to the receive DMA; same field positions regardless of byte order mode [R14]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      grant <= '0;
    end else if ((state_reg == RFQ_WAIT) && mem_rd_valid) begin
      grant.data_buffer_addr <= entry.dword0; // [R2]
      grant.descriptor_ptr <= entry.dword1[15:0]; // [R3] [R4]
      grant.descriptor_addr <= {desc_base_high_reg, desc_base_low_reg} + {12'h000, entry.dword1[15:0], 4'h0}; // [R3]
      grant.buffer_size <= use_small_reg ? small_size_reg : large_size_reg; // [R6]
      grant.channel <= chan_reg;
    end
  end

  // large read pointer: zero after reset, host may program, device advances [R9] [R19]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      large_rd_reg <= PTR_RESET; // [R19]
    end else if (large_adv) begin
      large_rd_reg <= rd_ptr_next; // [R15]
    end else if (reg_wr && hit(reg_addr, OFF_LARGE_RD)) begin
      large_rd_reg <= reg_wdata[15:0]; // [R9]
    end
  end

  // small read pointer; an advance beats a host write in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      small_rd_reg <= PTR_RESET; // [R19]
    end else if (small_adv) begin
      small_rd_reg <= rd_ptr_next; // [R15]
    end else if (reg_wr && hit(reg_addr, OFF_SMALL_RD)) begin
      small_rd_reg <= reg_wdata[15:0]; // [R9]
    end
  end

  // queue geometry, written by the host at initialisation [R5] [R8] [R9]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      base_low_reg <= PTR_RESET;
      base_high_reg <= PTR_RESET;
      end_addr_reg <= PTR_RESET;
      small_start_reg <= PTR_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_BASE_LOW)) begin
        base_low_reg <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OFF_BASE_HIGH)) begin
        base_high_reg <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OFF_END_ADDR)) begin
        end_addr_reg <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OFF_SMALL_START)) begin
        small_start_reg <= reg_wdata[15:0]; // [R8]
      end
    end
  end

  // host write pointers; only software moves them, keeping one slot free is its duty [R1] [R9] [R11]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      large_wr_reg <= PTR_RESET;
      small_wr_reg <= PTR_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_LARGE_WR)) begin
        large_wr_reg <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OFF_SMALL_WR)) begin
        small_wr_reg <= reg_wdata[15:0];
      end
    end
  end

  // descriptor base for the pointer-to-address step [R3]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      desc_base_low_reg <= PTR_RESET;
      desc_base_high_reg <= PTR_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_DESC_BASE_LOW)) begin
        desc_base_low_reg <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OFF_DESC_BASE_HIGH)) begin
        desc_base_high_reg <= reg_wdata[15:0];
      end
    end
  end

  // receive enable; clearing it stops new fetches but lets one in flight finish [R18]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_enable_reg <= 1'b0;
    end else if (reg_wr && hit(reg_addr, OFF_CTRL)) begin
      ctrl_enable_reg <= reg_wdata[CTRL_RX_ENABLE_BIT];
    end
  end

  // interrupt mask, same layout as the status register [R16]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= FLAGS_RESET;
    end else if (reg_wr && hit(reg_addr, OFF_MASK)) begin
      mask_reg <= reg_wdata[3:0];
    end
  end

  // buffer sizes handed out with each grant [R6]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      large_size_reg <= SIZE_RESET;
      small_size_reg <= SIZE_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_LARGE_SIZE)) begin
        large_size_reg <= reg_wdata[12:0];
      end
      if (hit(reg_addr, OFF_SMALL_SIZE)) begin
        small_size_reg <= reg_wdata[12:0];
      end
    end
  end

  // per-channel buffer size selection, one register each [R6] [R8]
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        chan_small_reg[i] <= 1'b0;
      end else if (reg_wr && hit(reg_addr, chan_off(i))) begin
        chan_small_reg[i] <= reg_wdata[0];
      end
    end
  end

  // sticky status; a new event in the clearing cycle wins [R16] [R17]
  always_comb begin
    status_set = FLAGS_RESET;
    status_set[ST_LARGE_DONE] = large_adv; // [R16]
    status_set[ST_SMALL_DONE] = small_adv; // [R16]
    status_set[ST_LARGE_UNDER] = (state_reg == RFQ_READ) && queue_empty && !use_small_reg; // [R17]
    status_set[ST_SMALL_UNDER] = (state_reg == RFQ_READ) && queue_empty && use_small_reg; // [R17]
  end

  // write-one-to-clear bits, zero when the status register is not addressed
  always_comb begin
    status_clr = FLAGS_RESET;
    if (reg_wr && hit(reg_addr, OFF_STATUS)) begin
      status_clr = reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= FLAGS_RESET;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set; // [R16] [R17]
    end
  end

  // interrupt follows the register one cycle later so the output stays a plain flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg); // [R16]
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      OFF_BASE_LOW: rdata_next[15:0] = base_low_reg;
      OFF_BASE_HIGH: rdata_next[15:0] = base_high_reg;
      OFF_END_ADDR: rdata_next[15:0] = end_addr_reg;
      OFF_SMALL_START: rdata_next[15:0] = small_start_reg;
      OFF_LARGE_WR: rdata_next[15:0] = large_wr_reg;
      OFF_SMALL_WR: rdata_next[15:0] = small_wr_reg;
      OFF_LARGE_RD: rdata_next[15:0] = large_rd_reg;
      OFF_SMALL_RD: rdata_next[15:0] = small_rd_reg;
      OFF_DESC_BASE_LOW: rdata_next[15:0] = desc_base_low_reg;
      OFF_DESC_BASE_HIGH: rdata_next[15:0] = desc_base_high_reg;
      OFF_CTRL: rdata_next[CTRL_RX_ENABLE_BIT] = ctrl_enable_reg;
      OFF_STATUS: rdata_next[3:0] = status_reg;
      OFF_MASK: rdata_next[3:0] = mask_reg;
      OFF_LARGE_SIZE: rdata_next[12:0] = large_size_reg;
      OFF_SMALL_SIZE: rdata_next[12:0] = small_size_reg;
      default: begin
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (reg_addr == chan_off(i)) begin
            rdata_next[0] = chan_small_reg[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule : rfq_manager

// file: rfq_manager_assertions.sv
// port-level checks of the free-queue manager
`timescale 1ns/100ps
module rfq_manager_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic fetch_req,
  input wire logic [rfq_pkg::CHAN_W-1:0] fetch_chan,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [63:0] mem_rd_data,
  input wire logic grant_valid,
  input wire rfq_pkg::rfq_grant_t grant,
  input wire logic fetch_error,
  input wire logic irq
);
  import rfq_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  chk_grant_follows: assert property (mem_rd_valid |=> grant_valid)
    else $error("grant missing after memory answer");
  chk_grant_cause: assert property (grant_valid |-> $past(mem_rd_valid))
    else $error("grant without memory answer");
  chk_buffer_addr: assert property (mem_rd_valid |=> grant.data_buffer_addr == $past(mem_rd_data[63:32]))
    else $error("buffer address not dword0");
  chk_desc_ptr: assert property (mem_rd_valid |=> grant.descriptor_ptr == $past(mem_rd_data[15:0]))
    else $error("descriptor pointer not low half of dword1");
  chk_empty_no_read: assert property (fetch_error |-> !mem_rd_req && !grant_valid)
    else $error("read issued on empty queue");
  chk_req_single: assert property (mem_rd_req |=> !mem_rd_req [*2])
    else $error("entry read repeated");
  chk_irq_cause: assert property ($rose(irq) |-> $past(grant_valid) || $past(fetch_error) || $past(reg_wr, 2))
    else $error("interrupt rose without cause");
  chk_reg_upper: assert property ($past(reg_rd) && $past(reg_addr[11:5]) == 7'h38 |-> reg_rdata[31:16] == 16'h0)
    else $error("queue register upper bits not zero");
  cover property (grant_valid);
  cover property (fetch_error);
  cover property ($rose(irq));
endmodule : rfq_manager_chk
bind rfq_manager rfq_manager_chk u_chk (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_chan(fetch_chan),
  .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
  .grant_valid(grant_valid), .grant(grant), .fetch_error(fetch_error), .irq(irq));

// file: rfq_pkg.sv
// package for the receive free-queue manager: register map, fields, reset values
package rfq_pkg;
  localparam logic [11:0] OFF_BASE_LOW = 12'h700;
  localparam logic [11:0] OFF_BASE_HIGH = 12'h704;
  localparam logic [11:0] OFF_END_ADDR = 12'h708;
  localparam logic [11:0] OFF_SMALL_START = 12'h70c;
  localparam logic [11:0] OFF_LARGE_WR = 12'h710;
  localparam logic [11:0] OFF_SMALL_WR = 12'h714;
  localparam logic [11:0] OFF_LARGE_RD = 12'h718;
  localparam logic [11:0] OFF_SMALL_RD = 12'h71c;
  localparam logic [11:0] OFF_DESC_BASE_LOW = 12'h750;
  localparam logic [11:0] OFF_DESC_BASE_HIGH = 12'h754;
  localparam logic [11:0] OFF_CTRL = 12'h7a0;
  localparam logic [11:0] OFF_STATUS = 12'h7a4;
  localparam logic [11:0] OFF_MASK = 12'h7a8;
  localparam logic [11:0] OFF_LARGE_SIZE = 12'h7ac;
  localparam logic [11:0] OFF_SMALL_SIZE = 12'h7b0;
  localparam logic [11:0] OFF_CHAN_SEL_BASE = 12'h7c0;
  localparam int NUM_CHAN = 8;
  localparam int CHAN_W = 3;
  localparam int CTRL_RX_ENABLE_BIT = 0;
  localparam int ST_LARGE_DONE = 0;
  localparam int ST_SMALL_DONE = 1;
  localparam int ST_LARGE_UNDER = 2;
  localparam int ST_SMALL_UNDER = 3;
  localparam int ENTRY_SHIFT = 3;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [12:0] SIZE_RESET = 13'h0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  typedef struct packed {
    logic [31:0] data_buffer_addr;
    logic [31:0] descriptor_addr;
    logic [15:0] descriptor_ptr;
    logic [12:0] buffer_size;
    logic [CHAN_W-1:0] channel;
  } rfq_grant_t;

  typedef struct packed {
    logic [31:0] dword0;
    logic [31:0] dword1;
  } rfq_entry_t;
endpackage : rfq_pkg

// file: tb.sv
// self-checking bench for the receive free-queue manager
`timescale 1ns/100ps
module tb;
  import rfq_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fetch_req = 1'b0;
  logic [2:0] fetch_chan = 3'h0;
  logic [3:0] slow = 4'h0;
  logic [31:0] reg_rdata, mem_rd_addr;
  logic [63:0] mem_rd_data;
  logic mem_rd_req, mem_rd_valid, grant_valid, fetch_error, irq;
  rfq_grant_t grant;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  rfq_manager u_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_chan(fetch_chan), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .grant_valid(grant_valid),
    .grant(grant), .fetch_error(fetch_error), .irq(irq));
  rfq_host_mem u_mem (.mclk(mclk), .rstn(rstn), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .slow(slow),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
  task automatic final_report;
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // the idle edge after each strobe keeps a driver from assigning a strobe twice in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("register", e, reg_rdata);
    @(posedge mclk);
  endtask : rdc
  task automatic fetch(input logic [2:0] ch, input logic err, input logic [31:0] ea, input logic [12:0] sz);
    int i;
    fetch_req <= 1'b1;
    fetch_chan <= ch;
    @(posedge mclk);
    fetch_req <= 1'b0;
    for (i = 0; i < 40 && grant_valid !== 1'b1 && fetch_error !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("fetch error", err, fetch_error);
    chk("grant valid", !err, grant_valid);
    if (!err) begin
      chk("entry address", ea, mem_rd_addr);
      chk("buffer address", ~ea, grant.data_buffer_addr);
      chk("descriptor pointer", ea[15:0], grant.descriptor_ptr);
      chk("descriptor address", 32'h2000 + {12'h0, ea[15:0], 4'h0}, grant.descriptor_addr);
      chk("buffer size", sz, grant.buffer_size);
      chk("channel", ch, grant.channel);
    end
    @(posedge mclk);
  endtask : fetch
  // a hang counts as a mismatch; the whole run needs under 150 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc(OFF_LARGE_RD, 32'h0);
    rdc(OFF_SMALL_RD, 32'h0);
    rdc(12'h7fc, 32'h0);
    fetch_req <= 1'b1;
    @(posedge mclk);
    fetch_req <= 1'b0;
    repeat (6) @(posedge mclk);
    rdc(OFF_STATUS, 32'h0);
    wr(OFF_BASE_LOW, 32'h1000);
    wr(OFF_BASE_HIGH, 32'h0);
    wr(OFF_END_ADDR, 32'h10);
    wr(OFF_SMALL_START, 32'h8);
    wr(OFF_LARGE_WR, 32'h2);
    wr(OFF_SMALL_WR, 32'h1);
    wr(OFF_DESC_BASE_LOW, 32'h2000);
    wr(OFF_DESC_BASE_HIGH, 32'h0);
    wr(OFF_MASK, 32'hf);
    wr(OFF_LARGE_SIZE, 32'h800);
    wr(OFF_SMALL_SIZE, 32'h100);
    wr(OFF_CHAN_SEL_BASE + 12'h4, 32'h1);
    wr(OFF_CTRL, 32'h1);
    rdc(OFF_LARGE_WR, 32'h2);
    fetch(3'h0, 1'b0, 32'h1000, 13'h800);
    slow <= 4'h3;
    fetch(3'h2, 1'b0, 32'h1008, 13'h800);
    rdc(OFF_LARGE_RD, 32'h2);
    fetch(3'h0, 1'b1, 32'h0, 13'h0);
    rdc(OFF_LARGE_RD, 32'h2);
    fetch(3'h1, 1'b0, 32'h1040, 13'h100);
    rdc(OFF_SMALL_RD, 32'h1);
    wr(OFF_LARGE_RD, 32'h7);
    wr(OFF_LARGE_WR, 32'h0);
    fetch(3'h0, 1'b0, 32'h1038, 13'h800);
    rdc(OFF_LARGE_RD, 32'h0);
    rdc(OFF_STATUS, 32'h7);
    chk("irq", 1'b1, irq);
    wr(OFF_STATUS, 32'h7);
    rdc(OFF_STATUS, 32'h0);
    chk("irq", 1'b0, irq);
    wr(OFF_MASK, 32'h0);
    fetch(3'h1, 1'b1, 32'h0, 13'h0);
    rdc(OFF_STATUS, 32'h8);
    chk("irq", 1'b0, irq);
    wr(OFF_MASK, 32'h8);
    rdc(OFF_SMALL_RD, 32'h1);
    chk("irq", 1'b1, irq);
    // small queue wrap: seven plus one plus the small start reaches the end address
    wr(OFF_SMALL_RD, 32'h7);
    wr(OFF_SMALL_WR, 32'h0);
    fetch(3'h1, 1'b0, 32'h1078, 13'h100);
    rdc(OFF_SMALL_RD, 32'h0);
    final_report();
  end
endmodule : tb
